/* common/regbank_pkg.sv */
// package: offsets, reset values, field positions and carrier types of the register bank
package regbank_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_CFG_ADDR = 8'h00;
    localparam logic [7:0] CHIP_IDENTIFIER_ADDR = 8'h01;
    localparam logic [7:0] CHAN_SEL_ADDR = 8'h05;
    localparam logic [7:0] COMMIT_ADDR = 8'hFF;
    localparam logic [7:0] SHADOW_FIRST = 8'h08;
    localparam logic [7:0] SHADOW_LAST = 8'h3E;
    localparam int SHADOW_DEPTH = 55;
    localparam int IDX_W = 6;
    // the one shadowed location kept as a single shared copy
    localparam logic [7:0] GLOBAL_SHADOW_ADDR = 8'h0B;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_CFG_RST = 8'h18;
    localparam logic [7:0] CHAN_SEL_RST = 8'hCF;
    localparam logic [7:0] COMMIT_RST = 8'h00;
    localparam logic [7:0] SHADOW_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_LSB_FIRST_HI = 6;
    localparam int CFG_LSB_FIRST_LO = 1;
    localparam int CFG_SOFT_RST_HI = 5;
    localparam int CFG_SOFT_RST_LO = 2;
    localparam logic [7:0] CFG_FIXED_ONES = 8'h18;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h66;
    localparam int SEL_CHAN_LSB = 0;
    localparam int NUM_CHAN = 4;
    localparam int SEL_PORT_AB = 6;
    localparam int SEL_PORT_CD = 7;
    localparam logic [7:0] CHAN_SEL_MASK = 8'hCF;
    localparam int COMMIT_BIT = 0;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } reg_rsp_type;

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------
    function automatic logic is_shadow(input logic [7:0] addr);
        is_shadow = (addr >= SHADOW_FIRST) && (addr <= SHADOW_LAST);
    endfunction

    function automatic logic is_local(input logic [7:0] addr);
        is_local = is_shadow(addr) && (addr != GLOBAL_SHADOW_ADDR);
    endfunction

    function automatic logic [IDX_W-1:0] shadow_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - SHADOW_FIRST;
        shadow_index = diff[IDX_W-1:0];
    endfunction

endpackage

/* rtl/shadow_bank.sv */
// one copy of the shadowed setup space: pending (shadow) and operating (active) storage
`timescale 1ns/1ns
module shadow_bank #(
    parameter int DEPTH = regbank_pkg::SHADOW_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [regbank_pkg::IDX_W-1:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic commit_i,
    input wire logic [regbank_pkg::IDX_W-1:0] rd_idx_i,
    output logic [7:0] shadow_data_o,
    input wire logic [regbank_pkg::IDX_W-1:0] act_idx_i,
    output logic [7:0] active_data_o
);

    logic [7:0] shadow_r [DEPTH];
    logic [7:0] shadow_nxt [DEPTH];
    logic [7:0] active_r [DEPTH];
    logic [7:0] active_nxt [DEPTH];

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            shadow_nxt[i] = shadow_r[i];
            // writes only land in the pending copy
            if (wr_en_i && (int'(wr_idx_i) == i)) begin
                shadow_nxt[i] = wr_data_i;
            end
            // every location moves over on the same edge
            active_nxt[i] = commit_i ? shadow_r[i] : active_r[i];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst_i) begin
                shadow_r[i] <= regbank_pkg::SHADOW_RST;
                active_r[i] <= regbank_pkg::SHADOW_RST;
            end else begin
                shadow_r[i] <= shadow_nxt[i];
                active_r[i] <= active_nxt[i];
            end
        end
    end

    // out-of-range indices read as zero rather than x
    assign shadow_data_o = (int'(rd_idx_i) < DEPTH) ? shadow_r[rd_idx_i] : 8'h00;
    assign active_data_o = (int'(act_idx_i) < DEPTH) ? active_r[act_idx_i] : 8'h00;

endmodule

/* rtl/shadowed_channel_register_bank.sv */
// register bank of a four-channel receiver: port config, id, channel select, shadow commit
`timescale 1ns/1ns
module shadowed_channel_register_bank #(
    parameter logic [7:0] CHIP_IDENTIFIER = 8'h5A  // arbitrary value, not a real part code
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input regbank_pkg::reg_req_type req_i,
    output regbank_pkg::reg_rsp_type rsp_o,
    input wire logic [1:0] act_chan_i,
    input wire logic [7:0] act_addr_i,
    output logic [7:0] act_data_o,
    output logic lsb_first_o,
    output logic [1:0] port_en_o,
    output logic [3:0] chan_sel_o,
    output logic commit_o,
    output logic soft_reset_o
);

    localparam int NUM_BANK = regbank_pkg::NUM_CHAN + 1;
    localparam int GLB = regbank_pkg::NUM_CHAN;

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    logic [7:0] port_cfg_r;
    logic [7:0] port_cfg_nxt;
    logic [7:0] chan_sel_r;
    logic [7:0] chan_sel_nxt;
    logic commit_r;
    logic commit_nxt;
    logic soft_rst_r;
    logic soft_rst_nxt;
    regbank_pkg::reg_rsp_type rsp_r;
    regbank_pkg::reg_rsp_type rsp_nxt;
    logic [7:0] act_data_r;
    logic [7:0] act_data_nxt;

    logic bank_rst;
    logic [NUM_BANK-1:0] bank_wr;
    logic [7:0] bank_shadow [NUM_BANK];
    logic [7:0] bank_active [NUM_BANK];
    logic [regbank_pkg::IDX_W-1:0] req_idx;
    logic [regbank_pkg::IDX_W-1:0] act_idx;
    logic [3:0] sel_chan;
    logic [1:0] first_chan;
    logic soft_req;

    // soft reset restores every register, including this port's own config
    assign bank_rst = rst_i | soft_rst_r;
    assign req_idx = regbank_pkg::shadow_index(req_i.addr);
    assign act_idx = regbank_pkg::shadow_index(act_addr_i);
    assign sel_chan = chan_sel_r[regbank_pkg::SEL_CHAN_LSB +: 4];

    // ------------------------------------------------------------
    // write steering into the five storage copies
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < regbank_pkg::NUM_CHAN; c++) begin
            // local write goes to every selected channel at once
            bank_wr[c] = req_i.wr && regbank_pkg::is_local(req_i.addr) && sel_chan[c];
        end
        // shared copy ignores the channel selection
        bank_wr[GLB] = req_i.wr && regbank_pkg::is_shadow(req_i.addr)
            && !regbank_pkg::is_local(req_i.addr);
    end

    for (genvar b = 0; b < NUM_BANK; b++) begin : g_bank
        shadow_bank #(
            .DEPTH(regbank_pkg::SHADOW_DEPTH)
        ) u_bank (
            .ref_clk_i(ref_clk_i),
            .rst_i(bank_rst),
            .wr_en_i(bank_wr[b]),
            .wr_idx_i(req_idx),
            .wr_data_i(req_i.wdata),
            .commit_i(commit_r),
            .rd_idx_i(req_idx),
            .shadow_data_o(bank_shadow[b]),
            .act_idx_i(act_idx),
            .active_data_o(bank_active[b])
        );
    end

    // ------------------------------------------------------------
    // lowest selected channel answers a local read
    // ------------------------------------------------------------
    always_comb begin
        first_chan = 2'd0;
        for (int c = regbank_pkg::NUM_CHAN - 1; c >= 0; c--) begin
            if (sel_chan[c]) begin
                first_chan = 2'(c);
            end
        end
    end

    // ------------------------------------------------------------
    // port config, channel select, commit and soft reset
    // ------------------------------------------------------------
    always_comb begin
        port_cfg_nxt = port_cfg_r;
        chan_sel_nxt = chan_sel_r;
        commit_nxt = 1'b0;
        soft_rst_nxt = 1'b0;
        soft_req = 1'b0;
        if (req_i.wr) begin
            case (req_i.addr)
                regbank_pkg::PORT_CFG_ADDR: begin
                    // either mirror position triggers, so bit order does not matter
                    soft_req = req_i.wdata[regbank_pkg::CFG_SOFT_RST_HI]
                        | req_i.wdata[regbank_pkg::CFG_SOFT_RST_LO];
                    port_cfg_nxt = (req_i.wdata & regbank_pkg::CFG_WRITE_MASK)
                        | regbank_pkg::CFG_FIXED_ONES;
                    soft_rst_nxt = soft_req;
                end
                regbank_pkg::CHAN_SEL_ADDR: begin
                    chan_sel_nxt = req_i.wdata & regbank_pkg::CHAN_SEL_MASK;
                end
                regbank_pkg::COMMIT_ADDR: begin
                    commit_nxt = req_i.wdata[regbank_pkg::COMMIT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read answer and datapath view of the operating settings
    // ------------------------------------------------------------
    always_comb begin
        rsp_nxt.valid = req_i.rd;
        rsp_nxt.data = regbank_pkg::UNMAPPED_READ;
        if (req_i.rd) begin
            if (regbank_pkg::is_local(req_i.addr)) begin
                rsp_nxt.data = bank_shadow[first_chan];
            end else if (regbank_pkg::is_shadow(req_i.addr)) begin
                rsp_nxt.data = bank_shadow[GLB];
            end else begin
                case (req_i.addr)
                    regbank_pkg::PORT_CFG_ADDR: rsp_nxt.data = port_cfg_r;
                    regbank_pkg::CHIP_IDENTIFIER_ADDR: rsp_nxt.data = CHIP_IDENTIFIER;
                    regbank_pkg::CHAN_SEL_ADDR: rsp_nxt.data = chan_sel_r;
                    regbank_pkg::COMMIT_ADDR: rsp_nxt.data = {7'h00, commit_r};
                    default: rsp_nxt.data = regbank_pkg::UNMAPPED_READ;
                endcase
            end
        end
        // converter logic sees only committed values, never pending ones
        if (regbank_pkg::is_local(act_addr_i)) begin
            act_data_nxt = bank_active[act_chan_i];
        end else if (regbank_pkg::is_shadow(act_addr_i)) begin
            act_data_nxt = bank_active[GLB];
        end else begin
            act_data_nxt = regbank_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            port_cfg_r <= regbank_pkg::PORT_CFG_RST;
            chan_sel_r <= regbank_pkg::CHAN_SEL_RST;
            commit_r <= 1'b0;
            soft_rst_r <= 1'b0;
            rsp_r <= '0;
            act_data_r <= 8'h00;
        end else if (soft_rst_r) begin
            // soft reset takes one cycle and then clears itself
            port_cfg_r <= regbank_pkg::PORT_CFG_RST;
            chan_sel_r <= regbank_pkg::CHAN_SEL_RST;
            commit_r <= 1'b0;
            soft_rst_r <= 1'b0;
            rsp_r <= rsp_nxt;
            act_data_r <= act_data_nxt;
        end else begin
            port_cfg_r <= port_cfg_nxt;
            chan_sel_r <= chan_sel_nxt;
            commit_r <= commit_nxt;
            soft_rst_r <= soft_rst_nxt;
            rsp_r <= rsp_nxt;
            act_data_r <= act_data_nxt;
        end
    end

    assign rsp_o = rsp_r;
    assign act_data_o = act_data_r;
    assign lsb_first_o = port_cfg_r[regbank_pkg::CFG_LSB_FIRST_HI]
        | port_cfg_r[regbank_pkg::CFG_LSB_FIRST_LO];
    assign port_en_o = {chan_sel_r[regbank_pkg::SEL_PORT_CD],
        chan_sel_r[regbank_pkg::SEL_PORT_AB]};
    assign chan_sel_o = sel_chan;
    assign commit_o = commit_r;
    assign soft_reset_o = soft_rst_r;

endmodule

/* tb/host_model.sv */
// serial control host: one byte request per call, changed on the falling edge
`timescale 1ns/1ns
module host_model (
    input wire logic ref_clk_i,
    output regbank_pkg::reg_req_type req_o,
    input regbank_pkg::reg_rsp_type rsp_i
);
    initial req_o = '0;
    // released address and data are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        req_o.wr = 1'b1;
        req_o.addr = a;
        req_o.wdata = d;
        @(negedge ref_clk_i);
        req_o.wr = 1'b0;
        req_o.addr = ~a;
        req_o.wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge ref_clk_i);
        req_o.rd = 1'b1;
        req_o.addr = a;
        @(negedge ref_clk_i);
        req_o.rd = 1'b0;
        req_o.addr = ~a;
        d = rsp_i.data;
        v = rsp_i.valid;
    endtask
    task automatic commit();
        wr(regbank_pkg::COMMIT_ADDR, 8'h01);
    endtask
endmodule

/* tb/regbank_checker_asserts.sv */
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module regbank_checker #(
    parameter logic [7:0] CHIP_IDENTIFIER = 8'h5A
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input regbank_pkg::reg_req_type req_i,
    input regbank_pkg::reg_rsp_type rsp_o,
    input wire logic [1:0] act_chan_i,
    input wire logic [7:0] act_addr_i,
    input wire logic [7:0] act_data_o,
    input wire logic lsb_first_o,
    input wire logic [1:0] port_en_o,
    input wire logic [3:0] chan_sel_o,
    input wire logic commit_o,
    input wire logic soft_reset_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // writes in the soft reset cycle are lost, so they are left out here
    logic wr_ok;
    assign wr_ok = req_i.wr && !soft_reset_o;
    // the copy lands on the edge that ends the commit pulse, so the registered view
    // moves one edge after that: look back one cycle for commit and soft reset
    property p_hold;
        $stable(act_chan_i) && $stable(act_addr_i) && !$past(commit_o)
            && !$past(soft_reset_o) |=> $stable(act_data_o);
    endproperty
    a_hold: assert property (p_hold) else $error("active value moved without commit");
    property p_commit;
        wr_ok && req_i.addr == 8'hFF && req_i.wdata[0] |=> commit_o;
    endproperty
    a_commit: assert property (p_commit) else $error("commit not raised");
    property p_autoclear;
        commit_o |=> !commit_o;
    endproperty
    a_autoclear: assert property (p_autoclear) else $error("commit did not clear");
    property p_sel;
        wr_ok && req_i.addr == 8'h05 |=> chan_sel_o == $past(req_i.wdata[3:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("channel select wrong");
    property p_port;
        wr_ok && req_i.addr == 8'h05 |=> port_en_o == $past(req_i.wdata[7:6]);
    endproperty
    a_port: assert property (p_port) else $error("port enables wrong");
    property p_lsb;
        wr_ok && req_i.addr == 8'h00 |=> lsb_first_o == ($past(req_i.wdata[6]) | $past(req_i.wdata[1]));
    endproperty
    a_lsb: assert property (p_lsb) else $error("bit order flag wrong");
    property p_soft;
        wr_ok && req_i.addr == 8'h00 && (req_i.wdata[5] || req_i.wdata[2]) |=> soft_reset_o ##1
            (chan_sel_o == 4'hF && port_en_o == 2'b11 && !lsb_first_o);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset not applied");
    // back-to-back reads are legal, so the second cycle follows the next strobe
    property p_rsp;
        req_i.rd |=> rsp_o.valid ##1 (rsp_o.valid == $past(req_i.rd));
    endproperty
    a_rsp: assert property (p_rsp) else $error("read answer timing wrong");
    property p_id;
        req_i.rd && req_i.addr == 8'h01 |=> rsp_o.data == CHIP_IDENTIFIER;
    endproperty
    a_id: assert property (p_id) else $error("identifier read wrong");
    c_commit: cover property (commit_o);
    c_soft: cover property (soft_reset_o);
    c_read: cover property (rsp_o.valid && rsp_o.data != 8'h00);
endmodule
bind shadowed_channel_register_bank regbank_checker #(.CHIP_IDENTIFIER(CHIP_IDENTIFIER)) regbank_checker_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i), .rsp_o(rsp_o),
    .act_chan_i(act_chan_i), .act_addr_i(act_addr_i), .act_data_o(act_data_o),
    .lsb_first_o(lsb_first_o), .port_en_o(port_en_o), .chan_sel_o(chan_sel_o),
    .commit_o(commit_o), .soft_reset_o(soft_reset_o));

/* tb/tb_shadowed_channel_register_bank.sv */
// self-checking bench for the shadowed channel register bank
`timescale 1ns/1ns
module tb_shadowed_channel_register_bank;
    localparam logic [7:0] ID = 8'hA3; // arbitrary identification value
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    regbank_pkg::reg_req_type req;
    regbank_pkg::reg_rsp_type rsp;
    logic [1:0] act_chan_i = 2'h0;
    logic [7:0] act_addr_i = 8'h08;
    logic [7:0] act_data_o;
    logic lsb_first_o, commit_o, soft_reset_o;
    logic [1:0] port_en_o;
    logic [3:0] chan_sel_o;
    int failures = 0;
    int num_checks = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    shadowed_channel_register_bank #(.CHIP_IDENTIFIER(ID)) shadowed_channel_register_bank_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
        .act_chan_i(act_chan_i), .act_addr_i(act_addr_i), .act_data_o(act_data_o),
        .lsb_first_o(lsb_first_o), .port_en_o(port_en_o), .chan_sel_o(chan_sel_o),
        .commit_o(commit_o), .soft_reset_o(soft_reset_o));
    host_model host_model_inst (.ref_clk_i(ref_clk_i), .req_o(req), .rsp_i(rsp));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string m);
        logic [7:0] d;
        logic v;
        host_model_inst.rd(a, d, v);
        chk({7'h00, v}, 8'h01, m);
        chk(d, exp, m);
    endtask
    // the active view answers one cycle after its address is presented
    task automatic act_chk(input logic [1:0] c, input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i);
        act_chan_i = c;
        act_addr_i = a;
        @(negedge ref_clk_i);
        chk(act_data_o, exp, "active value");
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        chk({4'h0, chan_sel_o}, 8'h0F, "reset select");
        chk({6'h00, port_en_o}, 8'h03, "reset ports");
        rdchk(8'h00, 8'h18, "port config reset");
        rdchk(8'h01, ID, "identifier");
        host_model_inst.wr(8'h01, 8'h00);
        rdchk(8'h01, ID, "identifier read only");
        rdchk(8'h05, 8'hCF, "select reset");
        rdchk(8'hFF, 8'h00, "commit reset");
        rdchk(8'h02, 8'h00, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_commit();
        host_model_inst.wr(8'h20, 8'h55);
        act_chk(2'd2, 8'h20, 8'h00);
        rdchk(8'h20, 8'h55, "pending value");
        host_model_inst.commit();
        chk({7'h00, commit_o}, 8'h01, "commit pulse");
        for (int c = 0; c < 4; c++) act_chk(c[1:0], 8'h20, 8'h55);
        rdchk(8'hFF, 8'h00, "commit cleared");
        $display("test commit done");
    endtask
    task automatic t_local();
        host_model_inst.wr(8'h05, 8'hC1);
        host_model_inst.wr(8'h30, 8'h11);
        host_model_inst.wr(8'h05, 8'hC2);
        host_model_inst.wr(8'h30, 8'h22);
        host_model_inst.wr(8'h05, 8'hCC);
        host_model_inst.wr(8'h30, 8'h33);
        host_model_inst.wr(8'h05, 8'hC6);
        rdchk(8'h30, 8'h22, "several selected");
        host_model_inst.wr(8'h05, 8'hC8);
        rdchk(8'h30, 8'h33, "channel D copy");
        host_model_inst.commit();
        act_chk(2'd0, 8'h30, 8'h11);
        act_chk(2'd1, 8'h30, 8'h22);
        act_chk(2'd2, 8'h30, 8'h33);
        host_model_inst.wr(8'h0B, 8'h07);
        host_model_inst.wr(8'h05, 8'hC1);
        rdchk(8'h0B, 8'h07, "global copy");
        host_model_inst.commit();
        act_chk(2'd3, 8'h0B, 8'h07);
        $display("test local done");
    endtask
    task automatic t_config();
        host_model_inst.wr(8'h00, 8'h40);
        chk({7'h00, lsb_first_o}, 8'h01, "upper order flag");
        rdchk(8'h00, 8'h58, "fixed ones kept");
        host_model_inst.wr(8'h00, 8'h02);
        chk({7'h00, lsb_first_o}, 8'h01, "lower order flag");
        host_model_inst.wr(8'h05, 8'h40);
        chk({6'h00, port_en_o}, 8'h01, "port A and B");
        host_model_inst.wr(8'h05, 8'h80);
        chk({6'h00, port_en_o}, 8'h02, "port C and D");
        host_model_inst.wr(8'h00, 8'h04);
        chk({7'h00, soft_reset_o}, 8'h01, "soft reset pulse");
        rdchk(8'h05, 8'hCF, "select restored");
        rdchk(8'h20, 8'h00, "storage cleared");
        $display("test config done");
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        t_reset();
        t_commit();
        t_local();
        t_config();
        wrap_up();
    end
    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule
